// ---- logic/pieb_top.sv ----
// What this block does
// (R1) no peripheral request reaches the core unless the group enable is set
// (R2) first enable register: bit 2 oscillator enable, other bits read zero
// (R3) second enable register: bit 1 cell two, bit 0 cell one, rest zero
// (R4) an enable of 1 passes its request, 0 blocks it
// (R5) all enable bits clear to zero on every reset
// (R6) flags set on their event regardless of any enable
// (R7) global enable 1 allows enabled interrupts, 0 suppresses all; the code gates only periph_irq_req_o with it, irq_o ignores it
// (R8) request = OR(flag AND enable) AND group enable AND global enable
module pieb_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic osc_accumulator_event_i,
  input wire logic logic_cell_one_event_i,
  input wire logic logic_cell_two_event_i,
  output logic periph_irq_req_o,
  output logic irq_o
);
  // ----------------------------------------
  // pin inputs: two-stage sync
  // ----------------------------------------
  logic [2:0] evt_meta;
  logic [2:0] evt_sync;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      evt_meta <= 3'h0;
      evt_sync <= 3'h0;
    end else if (ce_i) begin
      evt_meta <= {logic_cell_two_event_i, logic_cell_one_event_i, osc_accumulator_event_i};
      evt_sync <= evt_meta;
    end
  end

  // ----------------------------------------
  // enable and control registers
  // ----------------------------------------
  logic [7:0] peripheral_irq_enable_one;
  logic [7:0] peripheral_irq_enable_two;
  logic [7:0] interrupt_control_register;
  logic [2:0] evt_enable;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  // unimplemented bits never store, so they always read zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      peripheral_irq_enable_one <= pieb_pkg::RST_ENABLE; // R5
    end else if (ce_i && wr_i && hit(addr_i, pieb_pkg::OFF_ENABLE_ONE)) begin
      peripheral_irq_enable_one <= wdata_i & pieb_pkg::MASK_ENABLE_ONE; // R2
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      peripheral_irq_enable_two <= pieb_pkg::RST_ENABLE; // R5
    end else if (ce_i && wr_i && hit(addr_i, pieb_pkg::OFF_ENABLE_TWO)) begin
      peripheral_irq_enable_two <= wdata_i & pieb_pkg::MASK_ENABLE_TWO; // R3
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      interrupt_control_register <= pieb_pkg::RST_ENABLE;
    end else if (ce_i && wr_i && hit(addr_i, pieb_pkg::OFF_CONTROL)) begin
      interrupt_control_register <= wdata_i & pieb_pkg::MASK_CONTROL;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      evt_enable <= 3'h0;
    end else if (ce_i && wr_i && hit(addr_i, pieb_pkg::OFF_EVT_ENABLE)) begin
      evt_enable <= wdata_i[2:0];
    end
  end

  // ----------------------------------------
  // peripheral flags and event status
  // ----------------------------------------
  logic [2:0] flags;
  logic [2:0] flag_clr;
  logic [2:0] evt_status;
  logic [2:0] evt_clr;
  assign flag_clr = (ce_i && wr_i && hit(addr_i, pieb_pkg::OFF_FLAGS)) ? wdata_i[2:0] : 3'h0;
  assign evt_clr = (ce_i && wr_i && hit(addr_i, pieb_pkg::OFF_EVT_CLEAR)) ? wdata_i[2:0] : 3'h0;

  pieb_flag_bank #(.N(pieb_pkg::NUM_SRC)) u_flags (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(evt_sync), // R6
    .clr_i(flag_clr),
    .flag_o(flags)
  );

  pieb_flag_bank #(.N(pieb_pkg::NUM_SRC)) u_status (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(evt_sync),
    .clr_i(evt_clr),
    .flag_o(evt_status)
  );

  // ----------------------------------------
  // request gating
  // ----------------------------------------
  logic [2:0] src_en;
  logic next_req;
  assign src_en = {peripheral_irq_enable_two[pieb_pkg::BIT_CELL_TWO_IE],
                   peripheral_irq_enable_two[pieb_pkg::BIT_CELL_ONE_IE],
                   peripheral_irq_enable_one[pieb_pkg::BIT_OSC_IE]}; // R4
  assign next_req = (|(flags & src_en)) // R8
                    && interrupt_control_register[pieb_pkg::BIT_GROUP_IE] // R1
                    && interrupt_control_register[pieb_pkg::BIT_GLOBAL_IE]; // R7

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      periph_irq_req_o <= 1'b0;
    end else if (ce_i) begin
      periph_irq_req_o <= next_req; // R8
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(evt_status & evt_enable);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr_i)
      pieb_pkg::OFF_ENABLE_ONE: next_rdata = peripheral_irq_enable_one; // R2
      pieb_pkg::OFF_ENABLE_TWO: next_rdata = peripheral_irq_enable_two; // R3
      pieb_pkg::OFF_CONTROL: next_rdata = interrupt_control_register;
      pieb_pkg::OFF_FLAGS: next_rdata = {5'h00, flags};
      pieb_pkg::OFF_EVT_STATUS: next_rdata = {5'h00, evt_status};
      pieb_pkg::OFF_EVT_ENABLE: next_rdata = {5'h00, evt_enable};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

  // ----------------------------------------
  // checks: request gating
  // ----------------------------------------
  // group and global gate the peripheral request; the enables only pick sources
  a_group_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R1
    ce_i && !interrupt_control_register[pieb_pkg::BIT_GROUP_IE] |=> !periph_irq_req_o)
    else $error("request without group enable");
  a_global_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R7
    ce_i && !interrupt_control_register[pieb_pkg::BIT_GLOBAL_IE] |=> !periph_irq_req_o)
    else $error("request without global enable");
  a_block_src: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R4
    ce_i && src_en == 3'h0 |=> !periph_irq_req_o)
    else $error("request with all enables off");
  a_req_full: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R8
    ce_i && next_req |=> periph_irq_req_o)
    else $error("enabled request not raised");
  a_none_pending: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R8
    ce_i && (flags & src_en) == 3'h0 |=> !periph_irq_req_o)
    else $error("request with no enabled flag");
  a_osc_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R4
    ce_i && flags[pieb_pkg::FLAG_OSC] && src_en[0] && interrupt_control_register[7:6] == 2'h3 |=> periph_irq_req_o)
    else $error("oscillator request blocked");
  a_one_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R4
    ce_i && flags[pieb_pkg::FLAG_CELL_ONE] && src_en[1] && interrupt_control_register[7:6] == 2'h3 |=> periph_irq_req_o)
    else $error("cell one request blocked");
  a_two_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R4
    ce_i && flags[pieb_pkg::FLAG_CELL_TWO] && src_en[2] && interrupt_control_register[7:6] == 2'h3 |=> periph_irq_req_o)
    else $error("cell two request blocked");

  // ----------------------------------------
  // checks: registers
  // ----------------------------------------
  a_one_reserved: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R2
    (peripheral_irq_enable_one & ~pieb_pkg::MASK_ENABLE_ONE) == 8'h00)
    else $error("reserved bit set in enable one");
  a_two_reserved: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R3
    (peripheral_irq_enable_two & ~pieb_pkg::MASK_ENABLE_TWO) == 8'h00)
    else $error("reserved bit set in enable two");
  a_ctrl_reserved: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (interrupt_control_register & ~pieb_pkg::MASK_CONTROL) == 8'h00)
    else $error("reserved bit set in control");
  a_write_one: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R2
    ce_i && wr_i && addr_i == pieb_pkg::OFF_ENABLE_ONE
    |=> peripheral_irq_enable_one == ($past(wdata_i) & pieb_pkg::MASK_ENABLE_ONE))
    else $error("enable one write lost");
  a_write_two: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R3
    ce_i && wr_i && addr_i == pieb_pkg::OFF_ENABLE_TWO
    |=> peripheral_irq_enable_two == ($past(wdata_i) & pieb_pkg::MASK_ENABLE_TWO))
    else $error("enable two write lost");
  a_write_ctrl: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && wr_i && addr_i == pieb_pkg::OFF_CONTROL
    |=> interrupt_control_register == ($past(wdata_i) & pieb_pkg::MASK_CONTROL))
    else $error("control write lost");
  a_reset_clear: assert property (@(posedge ref_clk_i) // R5
    rst_i |=> peripheral_irq_enable_one == 8'h00 && peripheral_irq_enable_two == 8'h00)
    else $error("enables not cleared by reset");
  a_out_reset: assert property (@(posedge ref_clk_i)
    rst_i |=> !periph_irq_req_o && !irq_o && rdata_o == 8'h00)
    else $error("outputs not cleared by reset");

  // ----------------------------------------
  // checks: read port
  // ----------------------------------------
  // idle read data is zero so several slaves can share one or-ed bus
  a_read_data: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && rd_i |=> rdata_o == $past(next_rdata))
    else $error("read data wrong");
  a_read_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data without read");
  a_read_one: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R2
    ce_i && rd_i && addr_i == pieb_pkg::OFF_ENABLE_ONE |=> (rdata_o & ~pieb_pkg::MASK_ENABLE_ONE) == 8'h00)
    else $error("enable one reads reserved bits");
  a_read_two: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R3
    ce_i && rd_i && addr_i == pieb_pkg::OFF_ENABLE_TWO |=> (rdata_o & ~pieb_pkg::MASK_ENABLE_TWO) == 8'h00)
    else $error("enable two reads reserved bits");
  a_read_unmapped: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && rd_i && addr_i > pieb_pkg::OFF_EVT_ENABLE |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // ----------------------------------------
  // checks: flags and interrupt
  // ----------------------------------------
  // an event shorter than one clock may slip past the synchroniser
  a_sync_pipe: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i |=> evt_sync == $past(evt_meta))
    else $error("synchroniser skipped a stage");
  a_flag_osc: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R6
    ce_i && evt_sync[0] |=> flags[0])
    else $error("oscillator flag missed its event");
  a_flag_event: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R6
    ce_i && evt_sync[1] |=> flags[1])
    else $error("flag missed its event");
  a_flag_two: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R6
    ce_i && evt_sync[2] |=> flags[2])
    else $error("cell two flag missed its event");
  a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && flag_clr[0] && !evt_sync[0] |=> !flags[0])
    else $error("flag clear ignored");
  a_status_event: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && evt_sync[0] |=> evt_status[0])
    else $error("status missed its event");
  a_irq_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && (evt_status & evt_enable) != 3'h0 |=> irq_o)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && (evt_status & evt_enable) == 3'h0 |=> !irq_o)
    else $error("interrupt without enabled status");

  // ----------------------------------------
  // checks: clock enable
  // ----------------------------------------
  // a low enable must hold outputs, or the core sees a glitch it never asked for
  a_freeze_req: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(periph_irq_req_o))
    else $error("request moved while frozen");
  a_freeze_irq: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(irq_o))
    else $error("interrupt moved while frozen");
  a_freeze_enables: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(peripheral_irq_enable_one) && $stable(peripheral_irq_enable_two))
    else $error("enables moved while frozen");
  a_freeze_rdata: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(rdata_o))
    else $error("read data moved while frozen");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_req: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(periph_irq_req_o));
  c_irq: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(irq_o));
  c_read: cover property (@(posedge ref_clk_i) disable iff (rst_i) rd_i ##1 rdata_o != 8'h00);
  c_clear_race: cover property (@(posedge ref_clk_i) disable iff (rst_i) ce_i && (flag_clr & evt_sync) != 3'h0);
endmodule

// ---- include/pieb_pkg.sv ----
package pieb_pkg;
  // ----------------------------------------
  // register map (word index == address)
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_ENABLE_ONE = 4'h0;
  localparam logic [3:0] OFF_ENABLE_TWO = 4'h1;
  localparam logic [3:0] OFF_CONTROL = 4'h2;
  localparam logic [3:0] OFF_FLAGS = 4'h3;
  localparam logic [3:0] OFF_EVT_STATUS = 4'h4;
  localparam logic [3:0] OFF_EVT_CLEAR = 4'h5;
  localparam logic [3:0] OFF_EVT_ENABLE = 4'h6;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_OSC_IE = 2;
  localparam int BIT_CELL_TWO_IE = 1;
  localparam int BIT_CELL_ONE_IE = 0;
  localparam int BIT_GLOBAL_IE = 7;
  localparam int BIT_GROUP_IE = 6;
  localparam int FLAG_OSC = 0;
  localparam int FLAG_CELL_ONE = 1;
  localparam int FLAG_CELL_TWO = 2;
  localparam int NUM_SRC = 3;
  // ----------------------------------------
  // reset values and implemented masks
  // ----------------------------------------
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] MASK_ENABLE_ONE = 8'h04;
  localparam logic [7:0] MASK_ENABLE_TWO = 8'h03;
  localparam logic [7:0] MASK_CONTROL = 8'hc0;
endpackage

// ---- logic/pieb_flag_bank.sv ----
// sticky flags: hardware set beats software clear
module pieb_flag_bank #(
  parameter int N = 3
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [N-1:0] set_i,
  input wire logic [N-1:0] clr_i,
  output logic [N-1:0] flag_o
);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_o <= '0;
    end else if (ce_i) begin
      flag_o <= (flag_o & ~clr_i) | set_i; // R6
    end
  end

  a_set_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && set_i[0] |=> flag_o[0]) else $error("flag set lost"); // R6
endmodule

// ---- bench/pieb_event_src.sv ----
// ----------------------------------------
// peripheral event sources, one cycle each
// ----------------------------------------
module pieb_event_src (
  input wire logic ref_clk_i,
  input wire logic [2:0] fire_i,
  output logic osc_o,
  output logic cell_one_o,
  output logic cell_two_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle level is low; a single high cycle stresses the synchroniser
  always_ff @(posedge ref_clk_i) begin
    osc_o <= fire_i[0];
    cell_one_o <= fire_i[1];
    cell_two_o <= fire_i[2];
  end
endmodule

// ---- bench/peripheral_interrupt_enable_bank_tb_top.sv ----
module peripheral_interrupt_enable_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ce = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [7:0] v;
  logic [2:0] fire = 3'h0;
  logic ev_osc, ev_one, ev_two, req, irq;
  int fails = 0;
  int n_checks = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  pieb_top pieb_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_accumulator_event_i(ev_osc),
    .logic_cell_one_event_i(ev_one), .logic_cell_two_event_i(ev_two), .periph_irq_req_o(req), .irq_o(irq));
  pieb_event_src pieb_event_src_i (.ref_clk_i(ref_clk_i), .fire_i(fire), .osc_o(ev_osc),
    .cell_one_o(ev_one), .cell_two_o(ev_two));
  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  // pin to request takes four cycles; six leaves margin
  task automatic pulse(input logic [2:0] m);
    @(posedge ref_clk_i);
    fire <= m;
    @(posedge ref_clk_i);
    fire <= 3'h0;
    nap(6);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    for (int a = 0; a < 3; a++) begin
      rd(a[3:0], v);
      chk("reset value", v, 8'h00);
    end
    wr(4'h0, 8'hff);
    wr(4'h1, 8'hff);
    wr(4'h2, 8'hff);
    rd(4'h0, v);
    chk("enable one", v, 8'h04);
    rd(4'h1, v);
    chk("enable two", v, 8'h03);
    rd(4'hf, v);
    chk("unmapped", v, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_path;
    for (int i = 0; i < 3; i++) begin
      pulse(3'(1 << i));
      chk("req enabled", {7'h00, req}, 8'h01);
      rd(4'h3, v);
      chk("flag", v, 8'(1 << i));
      wr(4'h3, 8'(1 << i));
      nap(3);
      chk("req cleared", {7'h00, req}, 8'h00);
    end
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    pulse(3'h7);
    chk("req blocked", {7'h00, req}, 8'h00);
    rd(4'h3, v);
    chk("flags unenabled", v, 8'h07);
    wr(4'h1, 8'h02);
    nap(3);
    chk("cell two pass", {7'h00, req}, 8'h01);
    wr(4'h2, 8'h80);
    nap(3);
    chk("group off", {7'h00, req}, 8'h00);
    wr(4'h2, 8'h40);
    nap(3);
    chk("global off", {7'h00, req}, 8'h00);
    $display("test path done");
  endtask
  task automatic t_irq;
    wr(4'h6, 8'h07);
    nap(3);
    chk("irq raised", {7'h00, irq}, 8'h01);
    wr(4'h6, 8'h00);
    nap(3);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(4'h5, 8'h07);
    wr(4'h6, 8'h07);
    nap(3);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    pulse(3'h1);
    chk("irq event", {7'h00, irq}, 8'h01);
    $display("test irq done");
  endtask
  task automatic t_ce;
    @(posedge ref_clk_i);
    ce <= 1'b0;
    wr(4'h0, 8'h04);
    @(posedge ref_clk_i);
    ce <= 1'b1;
    rd(4'h0, v);
    chk("frozen write", v, 8'h00);
    $display("test ce done");
  endtask
  task automatic t_rst;
    wr(4'h0, 8'h04);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    nap(2);
    rst_i <= 1'b0;
    rd(4'h0, v);
    chk("rerst one", v, 8'h00);
    rd(4'h1, v);
    chk("rerst two", v, 8'h00);
    chk("rerst req", {7'h00, req}, 8'h00);
    $display("test reset done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #40000;
    fails++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_path;
    t_irq;
    t_ce;
    t_rst;
    final_report;
  end
endmodule
